// ---- logic/msc_pkg.sv ----
package msc_pkg;

  // ==========================================================
  // register map
  localparam logic [31:0] ADDR_GSTA       = 32'hFFF0_30B4;
  localparam logic [31:0] ADDR_MPC        = 32'hFFF0_30B8;
  localparam logic [31:0] ADDR_IRQ_STATUS = 32'hFFF0_3100;
  localparam logic [31:0] ADDR_IRQ_MASK   = 32'hFFF0_3104;

  // ==========================================================
  // general status fields
  localparam int GSTA_TX_HALT  = 11;
  localparam int GSTA_SQE      = 10;
  localparam int GSTA_PAUSE    = 9;
  localparam int GSTA_DEFER    = 8;
  localparam int GSTA_COLL_MSB = 7;
  localparam int GSTA_COLL_LSB = 4;
  localparam int GSTA_RX_FULL  = 2;
  localparam int GSTA_RX_HALT  = 1;
  localparam int GSTA_CFR      = 0;
  localparam logic [11:0] GSTA_USED  = 12'hFF7;
  localparam logic [11:0] GSTA_RESET = 12'h000;
  localparam logic [3:0]  COLL_LAST  = 4'hF;
  localparam logic [2:0]  RX_FULL_PACKETS = 3'h4;

  // ==========================================================
  // missed packet counter
  localparam logic [15:0] MPC_RESET = 16'h7FFF;
  localparam logic [15:0] MPC_MAX   = 16'hFFFF;

  // ==========================================================
  // local interrupt status and mask
  localparam int IRQ_MISSED = 0;
  localparam int IRQ_ABORT  = 1;
  localparam logic [1:0] IRQ_RESET = 2'h0;

  // ==========================================================
  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic        aw_held;
    logic [31:0] aw_addr;
    logic        w_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [11:0] gsta;
    logic        abort;
    logic        rx_full;
    logic [1:0]  irq_status;
    logic [1:0]  irq_mask;
    logic        irq;
  } msc_top_state_t;

  typedef struct packed {
    logic [15:0] count;
    logic        overflow;
  } msc_cnt_state_t;

  function automatic logic [31:0] msc_strobe_mask(input logic [3:0] strb);
    return {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction

endpackage

// ---- logic/msc_cnt_if.sv ----
`timescale 1ns/1ns
interface msc_cnt_if;
  logic        load;
  logic [15:0] load_data;
  logic        read_clear;
  logic        drop;
  logic [15:0] count;
  logic        overflow;

  modport owner (output load, output load_data, output read_clear, output drop,
                 input count, input overflow);
  modport counter (input load, input load_data, input read_clear, input drop,
                   output count, output overflow);
endinterface

// ---- logic/msc_miss_counter.sv ----
`timescale 1ns/1ns
module msc_miss_counter
  import msc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  msc_cnt_if.counter cnt
);

  msc_cnt_state_t st;
  msc_cnt_state_t next_st;

  // ==========================================================
  // counter
  // load beats read clear; a drop in the same cycle still counts
  always_comb begin
    next_st = st;
    next_st.overflow = 1'b0;
    if (cnt.load) begin
      next_st.count = cnt.load_data;
    end else if (cnt.read_clear) begin
      next_st.count = 16'h0000;
    end
    if (cnt.drop) begin
      next_st.overflow = (next_st.count == MPC_MAX);
      next_st.count = next_st.count + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st <= '{count: MPC_RESET, overflow: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign cnt.count    = st.count;
  assign cnt.overflow = st.overflow;

  // ==========================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_cnt_reset;
    @(posedge sys_clk) disable iff (1'b0) ($past(rst) && !rst) |-> st.count == MPC_RESET;
  endproperty
  a_cnt_reset: assert property (p_cnt_reset) else $error("counter reset value wrong");

  property p_cnt_inc;
    (cnt.drop && !cnt.load && !cnt.read_clear) |=> st.count == $past(st.count) + 16'h0001;
  endproperty
  a_cnt_inc: assert property (p_cnt_inc) else $error("drop not counted");

  property p_cnt_load;
    (cnt.load && !cnt.drop) |=> st.count == $past(cnt.load_data);
  endproperty
  a_cnt_load: assert property (p_cnt_load) else $error("preload not taken");

  property p_cnt_wrap;
    (cnt.drop && !cnt.load && !cnt.read_clear && st.count == MPC_MAX)
      |=> st.overflow && st.count == 16'h0000 ##1 !st.overflow;
  endproperty
  a_cnt_wrap: assert property (p_cnt_wrap) else $error("overflow not reported");

endmodule

// ---- logic/msc_status_top.sv ----
`timescale 1ns/1ns
module msc_status_top
  import msc_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        transmit_enable,
  input  wire logic        receive_enable,
  input  wire logic        signal_quality_check_enable,
  input  wire logic        speed_10m,
  input  wire logic        full_duplex,
  input  wire logic        tx_end_sqe_fault,
  input  wire logic        pause_active,
  input  wire logic        tx_deferred,
  input  wire logic        tx_start,
  input  wire logic        tx_collision,
  input  wire logic [2:0]  rx_fifo_packets,
  input  wire logic        flow_ctrl_frame_in,
  input  wire logic        rx_drop_overflow,
  input  wire logic        rx_drop_disabled,
  input  wire logic        rx_crc_error,
  output logic             receive_fifo_full,
  output logic             transmit_abort_flag,
  output logic             missed_count_overflow,
  output logic             irq
);

  msc_top_state_t st;
  msc_top_state_t next_st;
  msc_cnt_if      cnt ();

  // ==========================================================
  // bus handshakes
  logic        aw_hs;
  logic        w_hs;
  logic        ar_hs;
  logic        do_write;
  logic [31:0] wr_mask;
  logic        wr_gsta;
  logic        wr_mpc;
  logic        wr_istat;
  logic        wr_imask;
  logic        wr_hit;

  assign aw_hs    = s_axi_awvalid & st.awready;
  assign w_hs     = s_axi_wvalid & st.wready;
  assign ar_hs    = s_axi_arvalid & st.arready;
  assign do_write = st.aw_held & st.w_held & ~st.bvalid;
  assign wr_mask  = msc_strobe_mask(st.w_strb) & st.w_data;
  assign wr_gsta  = do_write && st.aw_addr == ADDR_GSTA;
  assign wr_mpc   = do_write && st.aw_addr == ADDR_MPC;
  assign wr_istat = do_write && st.aw_addr == ADDR_IRQ_STATUS;
  assign wr_imask = do_write && st.aw_addr == ADDR_IRQ_MASK;
  assign wr_hit   = wr_gsta | wr_mpc | wr_istat | wr_imask;

  // ==========================================================
  // missed packet counter
  logic [31:0] mpc_merge;
  logic [31:0] keep_mask;

  // bytes left unstrobed keep their old value
  assign keep_mask = ~msc_strobe_mask(st.w_strb);
  assign mpc_merge = ({16'h0000, cnt.count} & keep_mask) | wr_mask;
  assign cnt.load       = wr_mpc;
  assign cnt.load_data  = mpc_merge[15:0];
  assign cnt.read_clear = ar_hs && s_axi_araddr == ADDR_MPC;
  assign cnt.drop       = rx_drop_overflow | rx_drop_disabled | rx_crc_error;

  msc_miss_counter u_counter (
    .sys_clk (sys_clk),
    .rst     (rst),
    .cnt     (cnt.counter)
  );

  // ==========================================================
  // next state
  always_comb begin
    logic [11:0] g;
    logic [11:0] clr;
    logic [3:0]  coll;
    logic [1:0]  iclr;
    g    = '0;
    clr  = '0;
    coll = '0;
    iclr = '0;
    next_st = st;

    // write channel: address and data taken in either order
    if (aw_hs) begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (w_hs) begin
      next_st.w_held = 1'b1;
      next_st.w_data = s_axi_wdata;
      next_st.w_strb = s_axi_wstrb;
    end
    if (do_write) begin
      next_st.aw_held = 1'b0;
      next_st.w_held  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    next_st.awready = ~next_st.aw_held & ~next_st.bvalid;
    next_st.wready  = ~next_st.w_held & ~next_st.bvalid;

    // general status: clear first, then hardware sets win
    if (wr_gsta) begin
      clr = wr_mask[11:0] & GSTA_USED;
    end
    g = st.gsta & ~clr;
    // a one anywhere in the tally field clears the whole field
    if (|clr[GSTA_COLL_MSB:GSTA_COLL_LSB]) begin
      g[GSTA_COLL_MSB:GSTA_COLL_LSB] = 4'h0;
    end
    if (!transmit_enable) begin
      g[GSTA_TX_HALT] = 1'b1;
    end
    if (tx_end_sqe_fault && signal_quality_check_enable && speed_10m && !full_duplex) begin
      g[GSTA_SQE] = 1'b1;
    end
    if (pause_active) begin
      g[GSTA_PAUSE] = 1'b1;
    end
    if (tx_deferred && !full_duplex) begin
      g[GSTA_DEFER] = 1'b1;
    end
    coll = tx_start ? 4'h0 : g[GSTA_COLL_MSB:GSTA_COLL_LSB];
    next_st.abort = 1'b0;
    if (tx_collision) begin
      next_st.abort = (coll == COLL_LAST);
      coll = coll + 4'h1;
    end
    g[GSTA_COLL_MSB:GSTA_COLL_LSB] = coll;
    next_st.rx_full = (rx_fifo_packets >= RX_FULL_PACKETS);
    if (next_st.rx_full) begin
      g[GSTA_RX_FULL] = 1'b1;
    end
    if (!receive_enable) begin
      g[GSTA_RX_HALT] = 1'b1;
    end
    if (flow_ctrl_frame_in && full_duplex) begin
      g[GSTA_CFR] = 1'b1;
    end
    next_st.gsta = g & GSTA_USED;

    // local interrupt status: only counter overflow and abort feed it
    if (wr_istat) begin
      iclr = wr_mask[1:0];
    end
    next_st.irq_status = st.irq_status & ~iclr;
    next_st.irq_status[IRQ_MISSED] = next_st.irq_status[IRQ_MISSED] | cnt.overflow;
    next_st.irq_status[IRQ_ABORT]  = next_st.irq_status[IRQ_ABORT] | st.abort;
    if (wr_imask) begin
      next_st.irq_mask = (st.irq_mask & keep_mask[1:0]) | wr_mask[1:0];
    end
    next_st.irq = |(next_st.irq_status & next_st.irq_mask);

    // read channel: value captured when the address is taken
    if (ar_hs) begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = RESP_OKAY;
      unique case (s_axi_araddr)
        ADDR_GSTA:       next_st.rdata = {20'h0_0000, st.gsta};
        ADDR_MPC:        next_st.rdata = {16'h0000, cnt.count};
        ADDR_IRQ_STATUS: next_st.rdata = {30'h0000_0000, st.irq_status};
        ADDR_IRQ_MASK:   next_st.rdata = {30'h0000_0000, st.irq_mask};
        default: begin
          next_st.rdata = 32'h0000_0000;
          next_st.rresp = RESP_SLVERR;
        end
      endcase
    end else if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    next_st.arready = ~next_st.rvalid;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st            <= '0;
      st.awready    <= 1'b1;
      st.wready     <= 1'b1;
      st.arready    <= 1'b1;
      st.gsta       <= GSTA_RESET;
      st.irq_status <= IRQ_RESET;
      st.irq_mask   <= IRQ_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // outputs, all from flops
  assign s_axi_awready         = st.awready;
  assign s_axi_wready          = st.wready;
  assign s_axi_bvalid          = st.bvalid;
  assign s_axi_bresp           = st.bresp;
  assign s_axi_arready         = st.arready;
  assign s_axi_rvalid          = st.rvalid;
  assign s_axi_rdata           = st.rdata;
  assign s_axi_rresp           = st.rresp;
  assign receive_fifo_full     = st.rx_full;
  assign transmit_abort_flag   = st.abort;
  assign missed_count_overflow = cnt.overflow;
  assign irq                   = st.irq;

  // ==========================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_gsta_cfr_clear;
    wr_gsta && wr_mask[GSTA_CFR] && !(flow_ctrl_frame_in && full_duplex);
  endsequence

  sequence s_coll_wrap;
    tx_collision && !tx_start && !wr_gsta && st.gsta[GSTA_COLL_MSB:GSTA_COLL_LSB] == COLL_LAST;
  endsequence

  // only counter overflow, abort or a mask write may raise irq, never a status flag
  property p_irq_source;
    $rose(irq) |-> $past(cnt.overflow || st.abort || wr_imask);
  endproperty
  a_irq_source: assert property (p_irq_source) else $error("irq without local cause");

  property p_w1c;
    s_gsta_cfr_clear |=> !st.gsta[GSTA_CFR];
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one did not clear flag");

  property p_tx_halt;
    !transmit_enable |=> st.gsta[GSTA_TX_HALT];
  endproperty
  a_tx_halt: assert property (p_tx_halt) else $error("transmit halt not shown");

  property p_sqe_cause;
    $rose(st.gsta[GSTA_SQE])
      |-> $past(tx_end_sqe_fault && signal_quality_check_enable && speed_10m && !full_duplex);
  endproperty
  a_sqe_cause: assert property (p_sqe_cause) else $error("fault flag set without check");

  property p_pause;
    pause_active |=> st.gsta[GSTA_PAUSE];
  endproperty
  a_pause: assert property (p_pause) else $error("pause flag missing");

  property p_defer;
    $rose(st.gsta[GSTA_DEFER]) |-> $past(tx_deferred && !full_duplex);
  endproperty
  a_defer: assert property (p_defer) else $error("defer flag set in full duplex");

  property p_coll_wrap;
    s_coll_wrap |=> st.gsta[GSTA_COLL_MSB:GSTA_COLL_LSB] == 4'h0 && transmit_abort_flag
      ##1 !transmit_abort_flag;
  endproperty
  a_coll_wrap: assert property (p_coll_wrap) else $error("16th collision not handled");

  property p_rx_full;
    rx_fifo_packets >= RX_FULL_PACKETS |=> st.gsta[GSTA_RX_FULL] && receive_fifo_full;
  endproperty
  a_rx_full: assert property (p_rx_full) else $error("fifo full not flagged");

  property p_rx_halt;
    !receive_enable |=> st.gsta[GSTA_RX_HALT];
  endproperty
  a_rx_halt: assert property (p_rx_halt) else $error("receive halt not shown");

  property p_cfr;
    $rose(st.gsta[GSTA_CFR]) |-> $past(flow_ctrl_frame_in && full_duplex);
  endproperty
  a_cfr: assert property (p_cfr) else $error("control frame flag outside full duplex");

  property p_mpc_read;
    (ar_hs && s_axi_araddr == ADDR_MPC)
      |=> s_axi_rvalid && s_axi_rdata == {16'h0000, $past(cnt.count)};
  endproperty
  a_mpc_read: assert property (p_mpc_read) else $error("counter read value wrong");

  property p_mpc_clear;
    (ar_hs && s_axi_araddr == ADDR_MPC && !cnt.drop && !wr_mpc) |=> cnt.count == 16'h0000;
  endproperty
  a_mpc_clear: assert property (p_mpc_clear) else $error("counter not cleared by read");

  property p_overflow_status;
    cnt.overflow |=> st.irq_status[IRQ_MISSED];
  endproperty
  a_overflow_status: assert property (p_overflow_status) else $error("overflow not latched");

  property p_abort_status;
    st.abort |=> st.irq_status[IRQ_ABORT];
  endproperty
  a_abort_status: assert property (p_abort_status) else $error("abort not latched");

  property p_w1c_keep;
    (wr_gsta && !wr_mask[GSTA_CFR] && st.gsta[GSTA_CFR]) |=> st.gsta[GSTA_CFR];
  endproperty
  a_w1c_keep: assert property (p_w1c_keep) else $error("write zero cleared flag");

  property p_rx_not_full;
    rx_fifo_packets < RX_FULL_PACKETS |=> !receive_fifo_full;
  endproperty
  a_rx_not_full: assert property (p_rx_not_full) else $error("fifo full shown early");

  property p_reserved;
    (ar_hs && s_axi_araddr == ADDR_GSTA)
      |=> s_axi_rdata[31:12] == 20'h0_0000 && s_axi_rdata[3] == 1'b0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits not zero");

endmodule

// ---- bench/testbench.sv ----
`timescale 1ns/1ns
module testbench;
  import msc_pkg::*;

  // ==========================================================
  // clock, reset, stimulus
  logic        sys_clk;
  logic        rst;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        transmit_enable, receive_enable, signal_quality_check_enable;
  logic        speed_10m, full_duplex, tx_end_sqe_fault, pause_active;
  logic        tx_deferred, tx_start, tx_collision, flow_ctrl_frame_in;
  logic        rx_drop_overflow, rx_drop_disabled, rx_crc_error;
  logic [2:0]  rx_fifo_packets;
  logic        receive_fifo_full, transmit_abort_flag, missed_count_overflow, irq;
  int          mismatches = 0;
  int          checks = 0;
  int          cycles = 0;

  msc_status_top msc_status_top_inst (.*);

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // whole run is well under 2000 cycles; the ceiling only cuts hangs
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      mismatches++;
      give_verdict();
    end
  end

  // ==========================================================
  // helpers
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      mismatches++;
    end
  endtask

  // handshakes are judged on values settled half a cycle before the edge
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w, b, done;
    logic [1:0] r;
    int n;
    done = 1'b0;
    @(posedge sys_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (n = 0; n < 40 && !done; n++) begin
      @(negedge sys_clk);
      aw = s_axi_awvalid && s_axi_awready;
      w  = s_axi_wvalid && s_axi_wready;
      b  = s_axi_bvalid && s_axi_bready;
      r  = s_axi_bresp;
      @(posedge sys_clk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (b) begin
        s_axi_bready <= 1'b0;
        done = 1'b1;
      end
    end
    chk({31'h0, done}, 32'h0000_0001);
    chk({30'h0, r}, {30'h0, er});
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ar, rv, done;
    logic [31:0] d;
    logic [1:0] r;
    int n;
    done = 1'b0;
    @(posedge sys_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (n = 0; n < 40 && !done; n++) begin
      @(negedge sys_clk);
      ar = s_axi_arvalid && s_axi_arready;
      rv = s_axi_rvalid && s_axi_rready;
      d  = s_axi_rdata;
      r  = s_axi_rresp;
      @(posedge sys_clk);
      if (ar) s_axi_arvalid <= 1'b0;
      if (rv) begin
        s_axi_rready <= 1'b0;
        done = 1'b1;
      end
    end
    chk({31'h0, done}, 32'h0000_0001);
    chk(d, ed);
    chk({30'h0, r}, {30'h0, er});
  endtask

  // one-cycle pulse on a status input chosen by code
  task automatic pulse(input int k);
    @(posedge sys_clk);
    case (k)
      0: rx_drop_overflow <= 1'b1;
      1: rx_drop_disabled <= 1'b1;
      2: rx_crc_error <= 1'b1;
      3: flow_ctrl_frame_in <= 1'b1;
      4: tx_deferred <= 1'b1;
      5: tx_end_sqe_fault <= 1'b1;
      default: tx_start <= 1'b1;
    endcase
    @(posedge sys_clk);
    {rx_drop_overflow, rx_drop_disabled, rx_crc_error} <= 3'h0;
    {flow_ctrl_frame_in, tx_deferred, tx_end_sqe_fault, tx_start} <= 4'h0;
  endtask

  task automatic collide(input int cnt);
    @(posedge sys_clk);
    tx_collision <= 1'b1;
    repeat (cnt) @(posedge sys_clk);
    tx_collision <= 1'b0;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    rst = 1'b1;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    s_axi_wstrb = 4'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {transmit_enable, receive_enable, full_duplex} = 3'h7;
    {signal_quality_check_enable, speed_10m, pause_active} = 3'h0;
    {tx_end_sqe_fault, tx_deferred, tx_start, tx_collision} = 4'h0;
    {flow_ctrl_frame_in, rx_drop_overflow, rx_drop_disabled, rx_crc_error} = 4'h0;
    rx_fifo_packets = 3'h0;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    rd(ADDR_GSTA, 32'h0000_0000, RESP_OKAY);
    rd(ADDR_MPC, 32'h0000_7fff, RESP_OKAY);
    rd(ADDR_MPC, 32'h0000_0000, RESP_OKAY);
    rd(32'hfff0_30bc, 32'h0000_0000, RESP_SLVERR);
    wr(32'hfff0_30bc, 32'hffff_ffff, RESP_SLVERR);
    // every drop cause counts once
    for (int k = 0; k < 3; k++) pulse(k);
    rd(ADDR_MPC, 32'h0000_0003, RESP_OKAY);
    wr(ADDR_MPC, 32'h0000_1234, RESP_OKAY);
    pulse(2);
    rd(ADDR_MPC, 32'h0000_1235, RESP_OKAY);
    wr(ADDR_MPC, 32'hffff_ffff, RESP_OKAY);
    rd(ADDR_MPC, 32'h0000_ffff, RESP_OKAY);
    wr(ADDR_MPC, 32'h0000_fffe, RESP_OKAY);
    pulse(0);
    pulse(1);
    @(negedge sys_clk);
    chk({31'h0, missed_count_overflow}, 32'h0000_0001);
    rd(ADDR_MPC, 32'h0000_0000, RESP_OKAY);
    // collisions: partial count, then the wrap at sixteen
    pulse(6);
    collide(3);
    rd(ADDR_GSTA, 32'h0000_0030, RESP_OKAY);
    collide(13);
    @(negedge sys_clk);
    chk({31'h0, transmit_abort_flag}, 32'h0000_0001);
    rd(ADDR_GSTA, 32'h0000_0000, RESP_OKAY);
    rd(ADDR_IRQ_STATUS, 32'h0000_0003, RESP_OKAY);
    wr(ADDR_IRQ_MASK, 32'h0000_0003, RESP_OKAY);
    @(negedge sys_clk);
    chk({31'h0, irq}, 32'h0000_0001);
    wr(ADDR_IRQ_STATUS, 32'h0000_0003, RESP_OKAY);
    @(negedge sys_clk);
    chk({31'h0, irq}, 32'h0000_0000);
    // level causes and a full duplex control frame, all unmasked
    pulse(3);
    @(posedge sys_clk);
    {transmit_enable, receive_enable, pause_active} <= 3'h1;
    rx_fifo_packets <= RX_FULL_PACKETS;
    repeat (3) @(posedge sys_clk);
    {transmit_enable, receive_enable, pause_active} <= 3'h6;
    rx_fifo_packets <= 3'h3;
    @(negedge sys_clk);
    chk({31'h0, receive_fifo_full}, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0000);
    rd(ADDR_GSTA, 32'h0000_0a07, RESP_OKAY);
    wr(ADDR_GSTA, 32'h0000_0000, RESP_OKAY);
    rd(ADDR_GSTA, 32'h0000_0a07, RESP_OKAY);
    wr(ADDR_GSTA, 32'h0000_0001, RESP_OKAY);
    rd(ADDR_GSTA, 32'h0000_0a06, RESP_OKAY);
    wr(ADDR_GSTA, 32'hffff_ffff, RESP_OKAY);
    rd(ADDR_GSTA, 32'h0000_0000, RESP_OKAY);
    // half duplex at 10 Mbps: fault and defer count, control frame ignored
    @(posedge sys_clk);
    {full_duplex, speed_10m, signal_quality_check_enable} <= 3'h3;
    for (int k = 3; k < 6; k++) pulse(k);
    rd(ADDR_GSTA, 32'h0000_0500, RESP_OKAY);
    wr(ADDR_GSTA, 32'h0000_0500, RESP_OKAY);
    // full duplex: neither fault check nor defer applies
    @(posedge sys_clk);
    full_duplex <= 1'b1;
    pulse(4);
    pulse(5);
    rd(ADDR_GSTA, 32'h0000_0000, RESP_OKAY);
    chk({31'h0, irq}, 32'h0000_0000);
    give_verdict();
  end
endmodule
